// *** hw/lfr_pkg.sv ***
package lfr_pkg;

    // Time base
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned HZ_PER_MHZ    = 1_000_000;
    localparam int unsigned CLK_MHZ       = CLK_HZ / HZ_PER_MHZ;
    localparam int unsigned US_PER_MS     = 1000;

    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned CNT_W         = 25;
    typedef logic [CNT_W-1:0] lfr_cnt_t;

    // Deglitch interval, typical
    localparam int unsigned DEGLITCH_US   = 40;
    localparam int unsigned DEGLITCH_CYC  = DEGLITCH_US * CLK_MHZ;

    // Report delay: grounded select pin gives the minimum
    localparam int unsigned MIN_DELAY_US  = 40;
    localparam int unsigned MIN_DELAY_CYC = MIN_DELAY_US * CLK_MHZ;

    // Resistor settings, and the open pin
    localparam int unsigned RES_5K_OHM    = 5_000;
    localparam int unsigned RES_20K_OHM   = 20_000;
    localparam int unsigned RES_250K_OHM  = 250_000;
    localparam int unsigned RES_MIN_OHM   = RES_5K_OHM;
    localparam int unsigned FLOAT_DELAY_MS = 340;

    // Delay in ms = 3.3 * R * 1e-4 + 3, kept in microseconds as 33/100 * R + 3000
    localparam int unsigned DLY_SLOPE_NUM = 33;
    localparam int unsigned DLY_SLOPE_DEN = 100;
    localparam int unsigned DLY_OFFSET_MS = 3;

    function automatic int unsigned res_delay_cyc(input int unsigned res_ohm);
        int unsigned us;
        us = (res_ohm * DLY_SLOPE_NUM) / DLY_SLOPE_DEN + DLY_OFFSET_MS * US_PER_MS;
        return us * CLK_MHZ;
    endfunction

    localparam int unsigned DLY_5K_CYC    = res_delay_cyc(RES_5K_OHM);
    localparam int unsigned DLY_20K_CYC   = res_delay_cyc(RES_20K_OHM);
    localparam int unsigned DLY_250K_CYC  = res_delay_cyc(RES_250K_OHM);
    localparam int unsigned DLY_FLOAT_CYC = FLOAT_DELAY_MS * US_PER_MS * CLK_MHZ;

    // Decoded state of the delay-select pin
    typedef enum logic [2:0] {
        LFR_DSEL_GND   = 3'h0,
        LFR_DSEL_5K    = 3'h1,
        LFR_DSEL_20K   = 3'h2,
        LFR_DSEL_250K  = 3'h3,
        LFR_DSEL_FLOAT = 3'h4
    } lfr_dsel_t;

    // Gray sequence idle -> deglitch -> fault -> release -> idle
    typedef enum logic [1:0] {
        LFR_IDLE    = 2'h0,
        LFR_DEGLIT  = 2'h1,
        LFR_FAULT   = 2'h3,
        LFR_RELEASE = 2'h2
    } lfr_state_t;

    // Raw detector flags
    typedef struct packed {
        logic [NUM_CH-1:0] string_open;
        logic [NUM_CH-1:0] short_gnd;
        logic [NUM_CH-1:0] current_set_pin_short;
        logic [NUM_CH-1:0] current_set_pin_open;
        logic [NUM_CH-1:0] out_float_or_gnd;
        logic              over_temp;
    } lfr_detect_t;

    // Variant straps, static in use
    typedef struct packed {
        logic report_gated;
        logic current_set_pin_open_check;
        logic line_is_input;
        logic all_off_on_fault;
    } lfr_strap_t;

    // Latched fault causes
    typedef struct packed {
        logic [NUM_CH-1:0] string_open;
        logic [NUM_CH-1:0] short_gnd;
        logic [NUM_CH-1:0] current_set_pin_short;
        logic [NUM_CH-1:0] current_set_pin_open;
        logic              over_temp;
    } lfr_cause_t;

    localparam lfr_cause_t CAUSE_NONE = '0;
    localparam logic LINE_LOW  = 1'b0;
    localparam logic LINE_HIGH = 1'b1;

endpackage

// *** hw/lfr_interval.sv ***
module lfr_interval (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            clk_en,
    input  wire logic            run,
    input  wire lfr_pkg::lfr_cnt_t term,
    output logic                 done
);
    import lfr_pkg::*;

    lfr_cnt_t cnt_q;
    lfr_cnt_t cnt_d;

    // Saturates at the terminal count so done stays high while run holds
    always_comb begin
        cnt_d = '0;
        if (run) begin
            if (cnt_q != term) begin
                cnt_d = cnt_q + lfr_cnt_t'(1);
            end else begin
                cnt_d = cnt_q;
            end
        end
    end

    assign done = run && (cnt_q == term);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// *** hw/lfr_fault_report.sv ***
// Contract
// - Fault line is active low, idles released high, may stay unconnected.
// - Enabled detection with any detector fault drives the fault line low.
// - Gated variants keep detection and actions running, drive low only when enabled.
// - Current-set open counts only when its output floats or is grounded.
// - Supply falling low clears all fault reporting state.
// - Detected fault is held off the line for the report delay.
// - Delay follows select pin: gnd 40us, 5k 4.65ms, 20k 9.60ms, 250k 85.5ms, open 340ms.
// - Resistor delay in ms equals 3.3 times R times 1e-4 plus 3.
// - Grounded select gives 40 us minimum; other settings use at least 5 kohm.
// - Input-capable variants switch all channels off while line is pulled low.
// - Wired lines: one device's fault pulls line low, all devices turn off.
// - Fault acted on only after persisting longer than the 40 us deglitch.
// - Fault absent for deglitch interval restores operation and releases the line.
module lfr_fault_report #(
    parameter int unsigned DLY_5K_CYC    = lfr_pkg::DLY_5K_CYC,
    parameter int unsigned DLY_20K_CYC   = lfr_pkg::DLY_20K_CYC,
    parameter int unsigned DLY_250K_CYC  = lfr_pkg::DLY_250K_CYC,
    parameter int unsigned DLY_FLOAT_CYC = lfr_pkg::DLY_FLOAT_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    input  wire logic                       supply_low,
    input  wire logic                       report_enable,
    input  wire lfr_pkg::lfr_strap_t        strap,
    input  wire lfr_pkg::lfr_detect_t       detect,
    input  wire lfr_pkg::lfr_dsel_t         report_delay_select,
    input  wire logic                       fault_line_n_i,
    output logic                            fault_line_n_o,
    output logic                            fault_line_n_oe,
    output logic                            fault_active,
    output logic                            fault_reported,
    output logic                            all_off,
    output logic [lfr_pkg::NUM_CH-1:0]      channel_off,
    output lfr_pkg::lfr_cause_t             fault_cause
);
    import lfr_pkg::*;

    // Supply drop acts like a reset of the whole reporting path
    logic clr;
    assign clr = rst || supply_low;

    // Qualified detector view
    lfr_cause_t        raw_cause;
    logic              raw_fault;
    logic [NUM_CH-1:0] current_set_pin_open_mask;

    always_comb begin
        current_set_pin_open_mask = '0;
        if (strap.current_set_pin_open_check) begin
            // Output floating or grounded marks the channel unused
            current_set_pin_open_mask = detect.current_set_pin_open & detect.out_float_or_gnd;
        end
        raw_cause.string_open = detect.string_open;
        raw_cause.short_gnd   = detect.short_gnd;
        raw_cause.current_set_pin_short  = detect.current_set_pin_short;
        raw_cause.current_set_pin_open   = current_set_pin_open_mask;
        raw_cause.over_temp   = detect.over_temp;
        raw_fault             = |raw_cause;
    end

    // Report delay terminal from the select pin
    lfr_cnt_t rep_term;

    always_comb begin
        case (report_delay_select)
            LFR_DSEL_GND:   rep_term = lfr_cnt_t'(MIN_DELAY_CYC - 1);
            LFR_DSEL_5K:    rep_term = lfr_cnt_t'(DLY_5K_CYC - 1);
            LFR_DSEL_20K:   rep_term = lfr_cnt_t'(DLY_20K_CYC - 1);
            LFR_DSEL_250K:  rep_term = lfr_cnt_t'(DLY_250K_CYC - 1);
            LFR_DSEL_FLOAT: rep_term = lfr_cnt_t'(DLY_FLOAT_CYC - 1);
            // Unlisted codes fall back to the longest, safest delay
            default:        rep_term = lfr_cnt_t'(DLY_FLOAT_CYC - 1);
        endcase
    end

    // Fault state machine
    lfr_state_t state_q;
    lfr_state_t state_d;
    logic       deg_run;
    logic       deg_done;
    lfr_cnt_t   deg_term;
    logic       rep_run;
    logic       rep_done;

    always_comb begin
        deg_run  = 1'b0;
        deg_term = lfr_cnt_t'(DEGLITCH_CYC);
        case (state_q)
            LFR_DEGLIT: begin
                // One extra cycle makes the persistence strictly longer
                deg_run  = raw_fault;
                deg_term = lfr_cnt_t'(DEGLITCH_CYC);
            end
            LFR_RELEASE: begin
                deg_run  = !raw_fault;
                deg_term = lfr_cnt_t'(DEGLITCH_CYC - 1);
            end
            default: begin
                deg_run  = 1'b0;
                deg_term = lfr_cnt_t'(DEGLITCH_CYC);
            end
        endcase
    end

    assign rep_run = (state_q == LFR_FAULT) || (state_q == LFR_RELEASE);

    lfr_interval u_deglitch (
        .clk    (clk),
        .rst    (clr),
        .clk_en (clk_en),
        .run    (deg_run),
        .term   (deg_term),
        .done   (deg_done)
    );

    lfr_interval u_report (
        .clk    (clk),
        .rst    (clr),
        .clk_en (clk_en),
        .run    (rep_run),
        .term   (rep_term),
        .done   (rep_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            LFR_IDLE: begin
                if (raw_fault) begin
                    state_d = LFR_DEGLIT;
                end
            end
            LFR_DEGLIT: begin
                if (!raw_fault) begin
                    state_d = LFR_IDLE;
                end else if (deg_done) begin
                    state_d = LFR_FAULT;
                end
            end
            LFR_FAULT: begin
                if (!raw_fault) begin
                    state_d = LFR_RELEASE;
                end
            end
            LFR_RELEASE: begin
                if (raw_fault) begin
                    state_d = LFR_FAULT;
                end else if (deg_done) begin
                    state_d = LFR_IDLE;
                end
            end
            default: begin
                state_d = LFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            state_q <= LFR_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Outputs and cause latch
    logic       confirmed;
    logic       ext_pull;
    logic       drive_low;
    lfr_cause_t cause_q;
    lfr_cause_t cause_d;
    logic       active_q;
    logic       active_d;
    logic       reported_q;
    logic       reported_d;
    logic       all_off_q;
    logic       all_off_d;
    logic [NUM_CH-1:0] ch_off_q;
    logic [NUM_CH-1:0] ch_off_d;
    logic       line_o_q;
    logic       line_o_d;
    logic       line_oe_q;
    logic       line_oe_d;

    assign confirmed = (state_d == LFR_FAULT) || (state_d == LFR_RELEASE);
    // Line read includes our own drive, so a reporting device shuts itself too
    assign ext_pull  = strap.line_is_input && (fault_line_n_i == LINE_LOW);

    always_comb begin
        cause_d = cause_q;
        if (!confirmed) begin
            cause_d = CAUSE_NONE;
        end else if (state_q == LFR_DEGLIT || state_q == LFR_FAULT) begin
            cause_d = cause_q | raw_cause;
        end

        // Detection and protective action never wait for the enable
        active_d  = confirmed;
        all_off_d = (confirmed && (strap.all_off_on_fault || cause_d.over_temp)) || ext_pull;
        for (int i = 0; i < NUM_CH; i++) begin
            ch_off_d[i] = all_off_d || (confirmed && cause_d.current_set_pin_short[i]);
        end

        // Delay elapsed while fault still confirmed
        reported_d = rep_done && confirmed;
        drive_low  = reported_d && (!strap.report_gated || report_enable);
        // Open drain: released high by the external pull-up when not driving
        line_oe_d  = drive_low;
        line_o_d   = drive_low ? LINE_LOW : LINE_HIGH;
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            cause_q    <= CAUSE_NONE;
            active_q   <= 1'b0;
            reported_q <= 1'b0;
            all_off_q  <= 1'b0;
            ch_off_q   <= '0;
            line_o_q   <= LINE_HIGH;
            line_oe_q  <= 1'b0;
        end else if (clk_en) begin
            cause_q    <= cause_d;
            active_q   <= active_d;
            reported_q <= reported_d;
            all_off_q  <= all_off_d;
            ch_off_q   <= ch_off_d;
            line_o_q   <= line_o_d;
            line_oe_q  <= line_oe_d;
        end
    end

    assign fault_line_n_o  = line_o_q;
    assign fault_line_n_oe = line_oe_q;
    assign fault_active    = active_q;
    assign fault_reported  = reported_q;
    assign all_off         = all_off_q;
    assign channel_off     = ch_off_q;
    assign fault_cause     = cause_q;

endmodule

// *** sim/lfr_fault_report_props.sv ***
module lfr_fault_report_props (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   supply_low,
    input wire logic                   report_enable,
    input wire lfr_pkg::lfr_strap_t    strap,
    input wire lfr_pkg::lfr_detect_t   detect,
    input wire logic                   fault_line_n_i,
    input wire logic                   fault_line_n_o,
    input wire logic                   fault_line_n_oe,
    input wire logic                   fault_active,
    input wire logic                   fault_reported,
    input wire logic                   all_off,
    input wire logic [lfr_pkg::NUM_CH-1:0] channel_off,
    input wire lfr_pkg::lfr_cause_t    fault_cause
);
    import lfr_pkg::*;
    logic        raw;
    logic        clr;
    logic [11:0] hi_q, hi_d, lo_q, lo_d;
    assign clr = rst | supply_low;
    assign raw = |{detect.string_open, detect.short_gnd, detect.current_set_pin_short, detect.over_temp,
                   detect.current_set_pin_open & detect.out_float_or_gnd & {NUM_CH{strap.current_set_pin_open_check}}};
    // Saturating run lengths of the raw fault level, high and low
    always_comb begin
        hi_d = raw ? hi_q + {11'h0, ~&hi_q} : 12'h0;
        lo_d = raw ? 12'h0 : lo_q + {11'h0, ~&lo_q};
    end
    always_ff @(posedge clk) begin
        hi_q <= clr ? 12'h0 : hi_d;
        lo_q <= clr ? 12'h0 : lo_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (clr);
    sequence s_report_live;
        fault_reported && (!strap.report_gated || report_enable);
    endsequence
    a_line_polarity: assert property (fault_line_n_o != fault_line_n_oe)
        else $error("line level and enable disagree");
    a_drive_needs_report: assert property (fault_line_n_oe |-> fault_reported)
        else $error("line driven before report delay");
    a_report_holdoff: assert property ($rose(fault_active) |-> !fault_reported [*8])
        else $error("report without hold-off");
    a_gate_holds_line: assert property ((strap.report_gated && !report_enable) [*2] |-> !fault_line_n_oe)
        else $error("line driven while reporting disabled");
    a_report_drives: assert property (s_report_live [*2] |-> fault_line_n_oe)
        else $error("reported fault not on line");
    a_supply_clears: assert property (@(posedge clk) disable iff (rst)
        supply_low |=> !fault_active && !fault_line_n_oe && fault_cause == CAUSE_NONE)
        else $error("supply drop left fault state");
    a_deglitch_min: assert property ($rose(fault_active) |-> hi_q > DEGLITCH_CYC)
        else $error("fault confirmed too early");
    a_release_bound: assert property (lo_q == DEGLITCH_CYC + 8 |-> !fault_active && fault_line_n_o)
        else $error("fault not released");
    a_input_off: assert property (strap.line_is_input && !fault_line_n_i |=> all_off)
        else $error("pulled line did not switch off");
    a_all_channels: assert property (all_off |-> channel_off == '1)
        else $error("channel left on");
endmodule
bind lfr_fault_report lfr_fault_report_props u_props (.clk, .rst, .supply_low, .report_enable, .strap,
    .detect, .fault_line_n_i, .fault_line_n_o, .fault_line_n_oe, .fault_active, .fault_reported,
    .all_off, .channel_off, .fault_cause);

// *** sim/lfr_peer_model.sv ***
module lfr_peer_model #(
    parameter int unsigned BLANK_CYC = 5000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic supply_low,
    input  wire logic dut_oe,
    input  wire logic peer_fault,
    output logic      line_n,
    output logic      host_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] blank_q, blank_d;
    // Pull-up keeps the released line high; any device may pull it low
    assign line_n = !(dut_oe || peer_fault);
    always_comb begin
        blank_d = blank_q + {12'h0, blank_q != 13'(BLANK_CYC)};
    end
    always_ff @(posedge clk) begin
        blank_q <= (rst || supply_low) ? 13'h0 : blank_d;
    end
    // Monitor ignores the line until blanking after supply rise ends
    assign host_fault = !line_n && blank_q == 13'(BLANK_CYC);
endmodule

// *** sim/lfr_fault_report_tb.sv ***
module lfr_fault_report_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lfr_pkg::*;
    localparam int D5K = 20, D20K = 30, D250K = 40, DFL = 50;
    logic              clk = 1'b0, rst = 1'b1, supply_low = 1'b0, report_enable = 1'b1, peer_fault = 1'b0;
    lfr_strap_t        strap = 4'h7;
    lfr_detect_t       det = '0;
    lfr_dsel_t         dsel = LFR_DSEL_GND;
    logic              line_n, line_o, line_oe, f_act, f_rep, all_off, host_fault;
    logic [NUM_CH-1:0] ch_off;
    lfr_cause_t        cause;
    int                errors = 0, n_checks = 0;
    always #10 clk = ~clk;
    lfr_fault_report #(.DLY_5K_CYC(D5K), .DLY_20K_CYC(D20K), .DLY_250K_CYC(D250K), .DLY_FLOAT_CYC(DFL)) uut (
        .clk(clk), .rst(rst), .clk_en(1'b1), .supply_low(supply_low), .report_enable(report_enable),
        .strap(strap), .detect(det), .report_delay_select(dsel), .fault_line_n_i(line_n),
        .fault_line_n_o(line_o), .fault_line_n_oe(line_oe), .fault_active(f_act),
        .fault_reported(f_rep), .all_off(all_off), .channel_off(ch_off), .fault_cause(cause));
    lfr_peer_model peer (.clk(clk), .rst(rst), .supply_low(supply_low), .dut_oe(line_oe),
        .peer_fault(peer_fault), .line_n(line_n), .host_fault(host_fault));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %0h", $time, what, got);
        end
    endtask
    // Cycle counts carry a few cycles of register slack
    task automatic chk_near(input int got, input int exp, input string what);
        n_checks++;
        if (got < exp - 4 || got > exp + 4) begin
            errors++;
            $display("wrong value at %0t: %s took %0d", $time, what, got);
        end
    endtask
    task automatic wait_lvl(ref logic sig, input logic lvl, output int n);
        n = 0;
        while (sig !== lvl && n < 6000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_glitch;
        det.short_gnd = 4'h2;
        cyc(DEGLITCH_CYC - 10);
        det = '0;
        cyc(20);
        chk(f_act, 1'b0, "glitch");
        $display("glitch test done");
    endtask
    task automatic t_delay(input lfr_dsel_t sel, input int d);
        int n;
        dsel = sel;
        det.string_open = 4'h1;
        wait_lvl(line_o, 1'b0, n);
        chk_near(n, DEGLITCH_CYC + d + 3, "report delay");
        chk({ch_off, line_n, cause.string_open}, 9'h1e1, "fault outputs");
        det = '0;
        wait_lvl(f_act, 1'b0, n);
        chk_near(n, DEGLITCH_CYC + 2, "release");
        cyc(1);
        chk({line_o, line_oe, cause}, {2'b10, CAUSE_NONE}, "released");
        $display("delay test done");
    endtask
    task automatic t_gated;
        int n;
        strap.report_gated = 1'b1;
        report_enable = 1'b0;
        det.over_temp = 1'b1;
        wait_lvl(f_rep, 1'b1, n);
        cyc(5);
        chk({f_act, f_rep, all_off, line_oe}, 4'b1110, "gated");
        report_enable = 1'b1;
        cyc(2);
        chk(line_oe, 1'b1, "enabled");
        supply_low = 1'b1;
        cyc(1);
        supply_low = 1'b0;
        cyc(1);
        chk({f_act, f_rep, line_oe, cause}, '0, "supply drop");
        det = '0;
        strap.report_gated = 1'b0;
        cyc(DEGLITCH_CYC + 10);
        $display("gated test done");
    endtask
    task automatic t_current_set_pin;
        det.current_set_pin_open = 4'h8;
        cyc(DEGLITCH_CYC + 20);
        chk(f_act, 1'b0, "open on used output");
        det.out_float_or_gnd = 4'h8;
        cyc(DEGLITCH_CYC + 8);
        chk({f_act, cause.current_set_pin_open}, 5'h18, "open on unused");
        det = '0;
        cyc(DEGLITCH_CYC + 10);
        $display("open test done");
    endtask
    task automatic t_peer;
        peer_fault = 1'b1;
        cyc(2);
        chk({all_off, ch_off, f_act, host_fault}, 7'h7d, "pulled low");
        // Monitor must ignore the still low line right after the supply comes back
        supply_low = 1'b1;
        cyc(1);
        supply_low = 1'b0;
        cyc(2);
        chk({all_off, host_fault}, 2'b10, "blanked after supply rise");
        strap.line_is_input = 1'b0;
        cyc(2);
        chk(all_off, 1'b0, "line not an input");
        peer_fault = 1'b0;
        $display("peer test done");
    endtask
    // Per-channel shutdown without the all-off variant, line not read back
    task automatic t_channel;
        strap.all_off_on_fault = 1'b0;
        det.current_set_pin_short = 4'h4;
        cyc(DEGLITCH_CYC + 8);
        chk({all_off, ch_off, cause.current_set_pin_short}, 9'h044, "single channel off");
        cyc(60);
        chk({line_oe, all_off}, 2'b10, "reported, others on");
        det = '0;
        cyc(DEGLITCH_CYC + 10);
        chk({line_oe, ch_off}, 5'h00, "channel restored");
        $display("channel test done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        fork
            begin
                #1_600_000;
                errors++;
                $display("wrong value at %0t: watchdog expired", $time);
                conclude();
            end
        join_none
        cyc(6);
        rst = 1'b0;
        cyc(2);
        t_glitch();
        t_delay(LFR_DSEL_GND, MIN_DELAY_CYC);
        t_delay(LFR_DSEL_5K, D5K);
        t_delay(LFR_DSEL_20K, D20K);
        t_delay(LFR_DSEL_250K, D250K);
        t_delay(LFR_DSEL_FLOAT, DFL);
        t_delay(lfr_dsel_t'(3'h5), DFL);
        t_gated();
        t_current_set_pin();
        t_peer();
        t_channel();
        conclude();
    end
endmodule
